// ---- gpio_pin_mux.sv ----
// Fifteen-pin mux with GPIO, three alternate sets and pin interrupts
// How it works
// - Fifteen pins, fourteen in small package
// - Three-bit selector picks GPIO or set
// - Each set wires pins to peripheral signals
// - Two PWM channels reach four pins
// - Pins 12, 13 GPIO input only, I2C open-drain
// - Every pin raises its own interrupt
// - Sense, both-edge, polarity bits pick trigger
// - Writing one clears pending, zero ignored
// - Enabled pending bits merge into one request
// - Reset: inputs, pulls per pin group
// - Pins undriven while reset asserted
// - Low power: all pins undriven, only pins 9-13 can wake
// - Upper selector resets with debug on 9, 10
// - GPIO output drives data when direction set
`timescale 1ns/100ps
module gpio_pin_mux
    import gpio_mux_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Package and power
    input wire logic i_small_package,
    input wire logic i_low_power,
    input wire logic [14:0] i_wake_enable,
    // Configuration
    input wire logic [14:0] i_gpio_data,
    input wire logic [14:0] i_gpio_data_we,
    input wire logic [14:0] i_pin_direction_bits,
    input wire logic [14:0] i_pull_enable,
    input wire logic i_pull_we,
    input wire logic [23:0] i_pin_function_select_low,
    input wire logic [20:0] i_pin_function_select_high,
    input wire logic i_fsel_we,
    // Interrupt configuration
    input wire logic [14:0] i_intr_sense_select,
    input wire logic [14:0] i_intr_both_edge_select,
    input wire logic [14:0] i_intr_event_polarity,
    input wire logic [14:0] i_intr_enable_bits,
    input wire logic [14:0] i_intr_clear_bits,
    // Pads
    input wire logic [14:0] i_pad,
    output logic [14:0] o_pad,
    output logic [14:0] o_pad_oe,
    output logic [14:0] o_pull_down_en,
    output logic [14:0] o_pull_up_en,
    // Peripheral outputs toward pads
    input wire logic i_pwm_channel_zero,
    input wire logic i_pwm_channel_one,
    input wire logic i_uart_txd,
    input wire logic i_uart_rts,
    input wire logic i_spi_clk_out,
    input wire logic i_spi_clk_oe,
    input wire logic i_spi_cs_out,
    input wire logic i_spi_cs_oe,
    input wire logic i_spi_mosi,
    input wire logic i_pdm_clock_line,
    input wire logic i_i2c2_clk_low,
    input wire logic i_i2c2_dat_low,
    input wire logic i_i2c1_clk_low,
    input wire logic i_i2c1_dat_low,
    // Peripheral inputs from pads
    output logic o_uart_rxd,
    output logic o_uart_cts,
    output logic o_spi_clk_in,
    output logic o_spi_cs_in,
    output logic o_spi_miso,
    output logic o_pdm_input_line,
    output logic o_i2c2_clk_in,
    output logic o_i2c2_dat_in,
    output logic o_i2c1_clk_in,
    output logic o_i2c1_dat_in,
    output logic o_dbg_clk,
    output logic o_dbg_dio,
    // Status
    output logic [14:0] o_pin_level,
    output logic [14:0] o_intr_pending,
    output logic o_irq
);
    logic [2:0] fsel_q [NUM_PINS];
    logic [14:0] data_q;
    logic [14:0] dir_q;
    logic [14:0] pull_q;
    logic [14:0] out_d;
    logic [14:0] oe_d;
    logic [14:0] sync;
    logic [14:0] pin_ok;
    gpio_irq_if irq_bus ();

    // Pin 14 absent on the small package
    assign pin_ok = i_small_package ? 15'h3FFF : 15'h7FFF;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                fsel_q[i] <= FSEL_LOW_RST[3*i +: 3];
            end
            for (int i = 8; i < NUM_PINS; i++) begin
                fsel_q[i] <= FSEL_HIGH_RST[4*(i-8) +: 3];
            end
        end else if (i_fsel_we) begin
            for (int i = 0; i < 8; i++) begin
                fsel_q[i] <= i_pin_function_select_low[3*i +: 3];
            end
            for (int i = 8; i < NUM_PINS; i++) begin
                fsel_q[i] <= i_pin_function_select_high[3*(i-8) +: 3];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_q <= '0;
            dir_q <= '0;
        end else begin
            data_q <= (data_q & ~i_gpio_data_we) | (i_gpio_data & i_gpio_data_we);
            dir_q <= i_pin_direction_bits;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pull_q <= PULL_DOWN_RST | PULL_UP_RST;
        end else if (i_pull_we) begin
            pull_q <= i_pull_enable;
        end
    end

    // Output side of the function map
    always_comb begin
        out_d = '0;
        oe_d = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (fsel_q[p] == FSEL_GPIO) begin
                out_d[p] = data_q[p];
                oe_d[p] = dir_q[p] & ~INPUT_ONLY_MASK[p];
            end
        end
        // Set one
        if (fsel_q[1] == FSEL_SET_ONE) begin out_d[1] = i_uart_rts; oe_d[1] = 1'b1; end
        if (fsel_q[PWM_CH0_SET1] == FSEL_SET_ONE) begin
            out_d[PWM_CH0_SET1] = i_pwm_channel_zero;
            oe_d[PWM_CH0_SET1] = 1'b1;
        end
        if (fsel_q[PWM_CH1_SET1] == FSEL_SET_ONE) begin
            out_d[PWM_CH1_SET1] = i_pwm_channel_one;
            oe_d[PWM_CH1_SET1] = 1'b1;
        end
        if (fsel_q[5] == FSEL_SET_ONE) begin out_d[5] = i_uart_txd; oe_d[5] = 1'b1; end
        if (fsel_q[6] == FSEL_SET_ONE) begin out_d[6] = i_uart_rts; oe_d[6] = 1'b1; end
        if (fsel_q[8] == FSEL_SET_ONE) begin out_d[8] = i_uart_txd; oe_d[8] = 1'b1; end
        if (fsel_q[14] == FSEL_SET_ONE) begin oe_d[14] = i_i2c1_clk_low; end
        // Set zero
        if (fsel_q[0] == FSEL_SET_ZERO) begin out_d[0] = i_spi_clk_out; oe_d[0] = i_spi_clk_oe; end
        if (fsel_q[8] == FSEL_SET_ZERO) begin out_d[8] = i_spi_clk_out; oe_d[8] = i_spi_clk_oe; end
        if (fsel_q[14] == FSEL_SET_ZERO) begin
            out_d[14] = i_spi_clk_out;
            oe_d[14] = i_spi_clk_oe;
        end
        if (fsel_q[1] == FSEL_SET_ZERO) begin out_d[1] = i_spi_cs_out; oe_d[1] = i_spi_cs_oe; end
        if (fsel_q[11] == FSEL_SET_ZERO) begin
            out_d[11] = i_spi_cs_out;
            oe_d[11] = i_spi_cs_oe;
        end
        if (fsel_q[2] == FSEL_SET_ZERO) begin out_d[2] = i_spi_mosi; oe_d[2] = 1'b1; end
        if (fsel_q[10] == FSEL_SET_ZERO) begin out_d[10] = i_spi_mosi; oe_d[10] = 1'b1; end
        // I2C pulls low only, open drain
        if (fsel_q[4] == FSEL_SET_ZERO) oe_d[4] = i_i2c2_clk_low;
        if (fsel_q[6] == FSEL_SET_ZERO) oe_d[6] = i_i2c2_clk_low;
        if (fsel_q[5] == FSEL_SET_ZERO) oe_d[5] = i_i2c2_dat_low;
        if (fsel_q[7] == FSEL_SET_ZERO) oe_d[7] = i_i2c2_dat_low;
        if (fsel_q[12] == FSEL_SET_ZERO) oe_d[12] = i_i2c1_clk_low;
        if (fsel_q[13] == FSEL_SET_ZERO) oe_d[13] = i_i2c1_dat_low;
        // Set two
        if (fsel_q[2] == FSEL_SET_TWO) begin out_d[2] = i_pdm_clock_line; oe_d[2] = 1'b1; end
        if (fsel_q[3] == FSEL_SET_TWO) begin out_d[3] = i_pdm_clock_line; oe_d[3] = 1'b1; end
        if (fsel_q[7] == FSEL_SET_TWO) begin out_d[7] = i_pdm_clock_line; oe_d[7] = 1'b1; end
        if (fsel_q[PWM_CH0_SET2] == FSEL_SET_TWO) begin
            out_d[PWM_CH0_SET2] = i_pwm_channel_zero;
            oe_d[PWM_CH0_SET2] = 1'b1;
        end
        if (fsel_q[PWM_CH1_SET2] == FSEL_SET_TWO) begin
            out_d[PWM_CH1_SET2] = i_pwm_channel_one;
            oe_d[PWM_CH1_SET2] = 1'b1;
        end
        oe_d = oe_d & pin_ok;
        if (i_low_power) begin
            oe_d = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pad <= '0;
            o_pad_oe <= '0;
            o_pull_down_en <= PULL_DOWN_RST;
            o_pull_up_en <= PULL_UP_RST;
        end else begin
            o_pad <= out_d;
            o_pad_oe <= oe_d;
            o_pull_down_en <= pull_q & PULL_DOWN_RST & pin_ok & (i_low_power ? '0 : 15'h7FFF);
            o_pull_up_en <= pull_q & PULL_UP_RST;
        end
    end

    // Input side: synchronised levels to peripherals
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_uart_rxd <= 1'b1;
            o_uart_cts <= 1'b0;
            o_spi_clk_in <= 1'b0;
            o_spi_cs_in <= 1'b1;
            o_spi_miso <= 1'b0;
            o_pdm_input_line <= 1'b0;
            o_i2c2_clk_in <= 1'b1;
            o_i2c2_dat_in <= 1'b1;
            o_i2c1_clk_in <= 1'b1;
            o_i2c1_dat_in <= 1'b1;
            o_dbg_clk <= 1'b0;
            o_dbg_dio <= 1'b0;
        end else begin
            o_uart_rxd <= fsel_q[4] == FSEL_SET_ONE ? sync[4]
                        : fsel_q[11] == FSEL_SET_ONE ? sync[11] : 1'b1;
            o_uart_cts <= fsel_q[0] == FSEL_SET_ONE ? sync[0]
                        : fsel_q[7] == FSEL_SET_ONE ? sync[7]
                        : fsel_q[13] == FSEL_SET_ONE ? sync[13] : 1'b0;
            o_spi_clk_in <= fsel_q[0] == FSEL_SET_ZERO ? sync[0]
                          : fsel_q[8] == FSEL_SET_ZERO ? sync[8]
                          : fsel_q[14] == FSEL_SET_ZERO ? sync[14] : 1'b0;
            o_spi_cs_in <= fsel_q[1] == FSEL_SET_ZERO ? sync[1]
                         : fsel_q[11] == FSEL_SET_ZERO ? sync[11] : 1'b1;
            o_spi_miso <= fsel_q[3] == FSEL_SET_ZERO ? sync[3]
                        : fsel_q[9] == FSEL_SET_ZERO ? sync[9] : 1'b0;
            o_pdm_input_line <= fsel_q[1] == FSEL_SET_TWO ? sync[1]
                              : fsel_q[6] == FSEL_SET_TWO ? sync[6]
                              : fsel_q[8] == FSEL_SET_TWO ? sync[8]
                              : fsel_q[14] == FSEL_SET_TWO ? sync[14] : 1'b0;
            o_i2c2_clk_in <= fsel_q[4] == FSEL_SET_ZERO ? sync[4]
                           : fsel_q[6] == FSEL_SET_ZERO ? sync[6] : 1'b1;
            o_i2c2_dat_in <= fsel_q[5] == FSEL_SET_ZERO ? sync[5]
                           : fsel_q[7] == FSEL_SET_ZERO ? sync[7] : 1'b1;
            o_i2c1_clk_in <= fsel_q[12] == FSEL_SET_ZERO ? sync[12]
                           : fsel_q[14] == FSEL_SET_ONE ? sync[14] : 1'b1;
            o_i2c1_dat_in <= fsel_q[13] == FSEL_SET_ZERO ? sync[13] : 1'b1;
            o_dbg_clk <= fsel_q[9] == FSEL_SET_ONE ? sync[9] : 1'b0;
            o_dbg_dio <= fsel_q[10] == FSEL_SET_ONE ? sync[10] : 1'b0;
        end
    end

    // Interrupt detection; in low power only wake pins raise o_irq
    assign irq_bus.level = i_pad & pin_ok;
    assign irq_bus.sense = i_intr_sense_select;
    assign irq_bus.both = i_intr_both_edge_select;
    assign irq_bus.polarity = i_intr_event_polarity;
    assign irq_bus.enable = i_intr_enable_bits;
    assign irq_bus.clear = i_intr_clear_bits;

    gpio_irq_detect u_detect (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .irq(irq_bus),
        .o_sync(sync)
    );

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_level <= '0;
            o_intr_pending <= '0;
            o_irq <= 1'b0;
        end else begin
            o_pin_level <= sync;
            o_intr_pending <= irq_bus.pending & irq_bus.enable;
            o_irq <= |(irq_bus.pending & irq_bus.enable
                      & (i_low_power ? (WAKE_MASK & i_wake_enable) : 15'h7FFF));
        end
    end

    property p_irq_merge;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_low_power && |(irq_bus.pending & irq_bus.enable)) |=> o_irq;
    endproperty
    a_irq_merge: assert property (p_irq_merge) else $error("irq not raised");

    property p_input_only;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (fsel_q[12] == FSEL_GPIO && fsel_q[13] == FSEL_GPIO) |=> (o_pad_oe[13:12] == 2'h0);
    endproperty
    a_input_only: assert property (p_input_only) else $error("input pin driven");

    property p_low_power_hiz;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_low_power |=> (o_pad_oe == 15'h0000);
    endproperty
    a_low_power_hiz: assert property (p_low_power_hiz) else $error("driven in sleep");

    property p_gpio_drive;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_low_power && fsel_q[0] == FSEL_GPIO && dir_q[0]) |=> (o_pad_oe[0] && o_pad[0] == $past(data_q[0]));
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) else $error("gpio not driven");

    property p_pwm_pin;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_low_power && fsel_q[4] == FSEL_SET_TWO) |=> (o_pad_oe[4] && o_pad[4] == $past(i_pwm_channel_zero));
    endproperty
    a_pwm_pin: assert property (p_pwm_pin) else $error("pwm not routed");
endmodule

// ---- gpio_mux_pkg.sv ----
// Shared constants for the pin mux and interrupt port
package gpio_mux_pkg;
    localparam int NUM_PINS = 15;
    localparam int NUM_PINS_SMALL = 14;
    localparam int FSEL_W = 3;
    localparam logic [2:0] FSEL_GPIO = 3'h0;
    localparam logic [2:0] FSEL_SET_ONE = 3'h1;
    localparam logic [2:0] FSEL_SET_ZERO = 3'h4;
    localparam logic [2:0] FSEL_SET_TWO = 3'h5;
    localparam logic [23:0] FSEL_LOW_RST = 24'h000000;
    // Reset word for pins 8..14 packs one pin per four-bit lane
    localparam logic [27:0] FSEL_HIGH_RST = 28'h0000110;
    localparam logic [14:0] PULL_DOWN_RST = 15'h41FF;
    localparam logic [14:0] PULL_UP_RST = 15'h0E00;
    localparam logic [14:0] INPUT_ONLY_MASK = 15'h3000;
    localparam logic [14:0] WAKE_MASK = 15'h3E00;
    localparam int PWM_CH0_SET1 = 2;
    localparam int PWM_CH1_SET1 = 3;
    localparam int PWM_CH0_SET2 = 4;
    localparam int PWM_CH1_SET2 = 5;
endpackage

// ---- gpio_irq_if.sv ----
// Interface carrying per-pin interrupt configuration and status
`timescale 1ns/100ps
interface gpio_irq_if;
    logic [14:0] level;
    logic [14:0] sense;
    logic [14:0] both;
    logic [14:0] polarity;
    logic [14:0] enable;
    logic [14:0] clear;
    logic [14:0] pending;
    modport ctrl (output level, sense, both, polarity, enable, clear, input pending);
    modport det (input level, sense, both, polarity, enable, clear, output pending);
endinterface

// ---- gpio_irq_detect.sv ----
// Per-pin synchroniser and edge or level interrupt detector
`timescale 1ns/100ps
module gpio_irq_detect
    import gpio_mux_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    gpio_irq_if.det irq,
    output logic [14:0] o_sync
);
    logic [14:0] meta_q;
    logic [14:0] sync_q;
    logic [14:0] prev_q;
    logic [14:0] pend_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= irq.level;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            logic rise;
            logic fall;
            logic hit;
            assign rise = sync_q[g] & ~prev_q[g];
            assign fall = ~sync_q[g] & prev_q[g];
            // Sense 1 is level, else edge; both overrides polarity
            assign hit = irq.sense[g] ? (sync_q[g] == irq.polarity[g])
                       : irq.both[g] ? (rise | fall)
                       : (irq.polarity[g] ? rise : fall);
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pend_q[g] <= 1'b0;
                end else if (hit) begin
                    pend_q[g] <= 1'b1; // Set wins over clear
                end else if (irq.clear[g]) begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq.pending = pend_q;
    assign o_sync = sync_q;

    property p_level_holds;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (irq.sense[0] && sync_q[0] == irq.polarity[0]) |=> pend_q[0];
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level lost");

    property p_clear_works;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (irq.clear[0] && !g_pin[0].hit) |=> !pend_q[0];
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("clear failed");

    property p_rise_sets;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!irq.sense[0] && !irq.both[0] && irq.polarity[0] && $rose(sync_q[0])) |=> pend_q[0];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rise missed");

    property p_both_sets;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!irq.sense[0] && irq.both[0] && $fell(sync_q[0])) |=> pend_q[0];
    endproperty
    a_both_sets: assert property (p_both_sets) else $error("both edge missed");

    property p_sync_delay;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ##2 (sync_q[4] == $past(irq.level[4], 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong");
endmodule

// ---- gpio_pad_model.sv ----
// Partner model of the pad wires, outside drivers and pull resistors
`timescale 1ns/100ps
module gpio_pad_model (
    // Clock
    input wire logic i_sys_clk,
    // Device side of the pads
    input wire logic [14:0] i_pad_out,
    input wire logic [14:0] i_pad_oe,
    input wire logic [14:0] i_pull_down_en,
    input wire logic [14:0] i_pull_up_en,
    // Outside drivers
    input wire logic [14:0] i_ext_en,
    input wire logic [14:0] i_ext_val,
    // Resolved wire level
    output logic [14:0] o_pad_level
);
    logic [14:0] float_q = 15'h2AAA;

    // Undriven, unpulled wire wanders every cycle
    always @(posedge i_sys_clk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 15; i++) begin
            if (i_pad_oe[i]) begin
                o_pad_level[i] = i_pad_out[i];
            end else if (i_ext_en[i]) begin
                o_pad_level[i] = i_ext_val[i];
            end else if (i_pull_up_en[i]) begin
                o_pad_level[i] = 1'b1;
            end else if (i_pull_down_en[i]) begin
                o_pad_level[i] = 1'b0;
            end else begin
                o_pad_level[i] = float_q[i];
            end
        end
    end
endmodule

// ---- gpio_pin_mux_with_interrupts_test.sv ----
// Self-checking bench for the pin mux and interrupt port
`timescale 1ns/100ps
module gpio_pin_mux_with_interrupts_test;
    import gpio_mux_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic small_pkg = 1'b0;
    logic low_power = 1'b0;
    logic pull_we = 1'b0;
    logic fsel_we = 1'b0;
    logic irq;
    logic [23:0] fsel_lo = 24'h000000;
    logic [20:0] fsel_hi = 21'h000000;
    logic [14:0] wake_en = 15'h0000, data = 15'h0000, data_we = 15'h0000, dir = 15'h0000;
    logic [14:0] pull_en = 15'h7FFF, sense = 15'h0000, both = 15'h0000, pol = 15'h0000;
    logic [14:0] ien = 15'h0000, clr = 15'h0000, ext_en = 15'h7FFF, ext_val = 15'h0000;
    logic [14:0] pad_in, pad_out, pad_oe, pull_dn, pull_up, pin_level, pending;
    logic [13:0] per = 14'h0000;
    logic [11:0] per_in;
    int bad_count = 0;
    int num_checks = 0;

    always #50 clk = ~clk;

    gpio_pin_mux dut (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_small_package(small_pkg),
        .i_low_power(low_power), .i_wake_enable(wake_en), .i_gpio_data(data),
        .i_gpio_data_we(data_we), .i_pin_direction_bits(dir), .i_pull_enable(pull_en),
        .i_pull_we(pull_we), .i_pin_function_select_low(fsel_lo),
        .i_pin_function_select_high(fsel_hi), .i_fsel_we(fsel_we),
        .i_intr_sense_select(sense), .i_intr_both_edge_select(both),
        .i_intr_event_polarity(pol), .i_intr_enable_bits(ien), .i_intr_clear_bits(clr),
        .i_pad(pad_in), .o_pad(pad_out), .o_pad_oe(pad_oe), .o_pull_down_en(pull_dn),
        .o_pull_up_en(pull_up), .i_pwm_channel_zero(per[0]), .i_pwm_channel_one(per[1]),
        .i_uart_txd(per[2]), .i_uart_rts(per[3]), .i_spi_clk_out(per[4]),
        .i_spi_clk_oe(per[5]), .i_spi_cs_out(per[6]), .i_spi_cs_oe(per[7]),
        .i_spi_mosi(per[8]), .i_pdm_clock_line(per[9]), .i_i2c2_clk_low(per[10]),
        .i_i2c2_dat_low(per[11]), .i_i2c1_clk_low(per[12]), .i_i2c1_dat_low(per[13]),
        .o_uart_rxd(per_in[0]), .o_uart_cts(per_in[1]), .o_spi_clk_in(per_in[2]),
        .o_spi_cs_in(per_in[3]), .o_spi_miso(per_in[4]), .o_pdm_input_line(per_in[5]),
        .o_i2c2_clk_in(per_in[6]), .o_i2c2_dat_in(per_in[7]), .o_i2c1_clk_in(per_in[8]),
        .o_i2c1_dat_in(per_in[9]), .o_dbg_clk(per_in[10]), .o_dbg_dio(per_in[11]),
        .o_pin_level(pin_level), .o_intr_pending(pending), .o_irq(irq)
    );

    gpio_pad_model pads (
        .i_sys_clk(clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pull_down_en(pull_dn),
        .i_pull_up_en(pull_up), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad_level(pad_in)
    );

    task automatic chk(input logic [14:0] exp, input logic [14:0] act);
        num_checks++;
        if (act !== exp) begin
            bad_count++;
            $display("unexpected at %0t ns: expected %h got %h", $time, exp, act);
        end
    endtask

    // Wait n rising edges, then settle at the falling edge
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic cfg(input logic [23:0] lo, input logic [20:0] hi, input logic [14:0] d,
                       input logic [14:0] dat, input logic [14:0] we);
        @(posedge clk);
        fsel_lo <= lo;
        fsel_hi <= hi;
        fsel_we <= 1'b1;
        dir <= d;
        data <= dat;
        data_we <= we;
        @(posedge clk);
        fsel_we <= 1'b0;
        data_we <= 15'h0000;
        ticks(3);
    endtask

    task automatic pulse_clear(input logic [14:0] bits);
        @(posedge clk);
        clr <= bits;
        @(posedge clk);
        clr <= 15'h0000;
        ticks(3);
    endtask

    task automatic t_reset;
        ticks(1);
        chk(15'h0000, pad_oe);
        chk(PULL_DOWN_RST, pull_dn);
        chk(PULL_UP_RST, pull_up);
        chk(15'h0000, pending | {14'h0000, irq});
        chk(15'h03C9, {3'h0, per_in});
        @(posedge clk);
        ext_val <= 15'h0600;
        ticks(4);
        chk(15'h0003, {13'h0000, per_in[11], per_in[10]});
        @(posedge clk);
        ext_val <= 15'h0000;
        pull_en <= 15'h0201;
        pull_we <= 1'b1;
        @(posedge clk);
        pull_we <= 1'b0;
        ticks(3);
        chk(15'h0000, {13'h0000, per_in[11], per_in[10]});
        chk(15'h0001, pull_dn);
        chk(15'h0200, pull_up);
        $display("t_reset done");
    endtask

    task automatic t_gpio_out;
        @(posedge clk);
        ext_val <= 15'h1000;
        cfg(24'h000000, 21'h000000, 15'h7FFF, 15'h2A55, 15'h7FFF);
        chk(15'h4FFF, pad_oe);
        chk(15'h0A55, pad_out & pad_oe);
        ticks(1);
        chk(15'h1A55, pin_level);
        cfg(24'h000000, 21'h000000, 15'h7FFF, 15'h7FFF, 15'h4000);
        chk(15'h4A55, pad_out & pad_oe);
        @(posedge clk);
        small_pkg <= 1'b1;
        ticks(3);
        chk(15'h0FFF, pad_oe);
        @(posedge clk);
        small_pkg <= 1'b0;
        cfg(24'h000000, 21'h000000, 15'h0000, 15'h0000, 15'h7FFF);
        chk(15'h0000, pad_oe);
        $display("t_gpio_out done");
    endtask

    task automatic t_pwm;
        logic [14:0] exp;
        // Pin 0 gets undefined code 2, pins 2..5 carry the two channels
        cfg(24'h02D242, 21'h000000, 15'h0001, 15'h0001, 15'h7FFF);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            per[0] <= (k == 0);
            per[1] <= (k != 0);
            ticks(3);
            exp = (k == 0) ? 15'h0014 : 15'h0028;
            chk(exp, pad_out & 15'h003C);
            chk(15'h003C, pad_oe & 15'h003D);
        end
        cfg(24'h000000, 21'h000000, 15'h0000, 15'h0000, 15'h7FFF);
        $display("t_pwm done");
    endtask

    task automatic t_irq_modes;
        // Each entry is sense, both-edge, polarity
        logic [2:0] mode [5] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101};
        logic idle;
        for (int m = 0; m < 5; m++) begin
            idle = mode[m][1] ? 1'b0 : ~mode[m][0];
            @(posedge clk);
            sense[0] <= mode[m][2];
            both[0] <= mode[m][1];
            pol[0] <= mode[m][0];
            ien <= 15'h0000;
            ext_val[0] <= idle;
            ticks(6);
            pulse_clear(15'h0001);
            @(posedge clk);
            ien <= 15'h0001;
            ticks(2);
            chk(15'h0000, {14'h0000, irq});
            @(posedge clk);
            ext_val[0] <= ~idle;
            @(negedge clk);
            chk(15'h0000, pending);
            ticks(5);
            chk(15'h0001, pending);
            chk(15'h0001, {14'h0000, irq});
            pulse_clear(15'h0002);
            chk(15'h0001, pending);
            pulse_clear(15'h0001);
            chk({14'h0000, mode[m][2]}, pending);
            if (mode[m][1]) begin
                @(posedge clk);
                ext_val[0] <= idle;
                ticks(5);
                chk(15'h0001, pending);
            end
            @(posedge clk);
            ien <= 15'h0000;
            ticks(2);
            chk(15'h0000, {14'h0000, irq});
        end
        $display("t_irq_modes done");
    endtask

    task automatic t_low_power;
        @(posedge clk);
        low_power <= 1'b1;
        wake_en <= 15'h0800;
        ien <= 15'h0801;
        sense <= 15'h0000;
        both <= 15'h0000;
        pol <= 15'h7FFF;
        ext_val <= 15'h0000;
        ticks(6);
        pulse_clear(15'h7FFF);
        cfg(24'h000000, 21'h000000, 15'h7FFF, 15'h7FFF, 15'h7FFF);
        chk(15'h0000, pad_oe);
        @(posedge clk);
        ext_val[0] <= 1'b1;
        ticks(6);
        chk(15'h0000, {14'h0000, irq});
        @(posedge clk);
        ext_val[11] <= 1'b1;
        ticks(6);
        chk(15'h0001, {14'h0000, irq});
        @(posedge clk);
        low_power <= 1'b0;
        $display("t_low_power done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        @(negedge clk);
        chk(15'h0000, pad_oe);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_gpio_out;
        t_pwm;
        t_irq_modes;
        t_low_power;
        tally_and_finish;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        tally_and_finish;
    end
endmodule
